/* File: eeprom_pkg.sv */
package eeprom_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned MCLK_MHZ       = 250;
  localparam int unsigned WRITE_CYCLE_MS = 5;
  localparam int unsigned WRITE_CYCLES   = WRITE_CYCLE_MS * 1000 * MCLK_MHZ;

  // ----------------------------------------------------------------
  // array geometry and bit framing
  // ----------------------------------------------------------------
  localparam logic [12:0] ADDR_TOP  = 13'h1fff;
  localparam logic [3:0]  BIT_ACK   = 4'h8;
  localparam logic [3:0]  BIT_LAST  = 4'h7;
  localparam logic [4:0]  PW_LAST   = 5'h07;
  localparam logic [4:0]  ZERO_LAST = 5'h01;
  localparam logic [4:0]  NEW_HALF  = 5'h08;
  localparam logic [4:0]  NEW_LAST  = 5'h0f;
  localparam logic [4:0]  NEW_COUNT = 5'h10;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_PW_READ   = 8'h80;
  localparam logic [7:0] CMD_PW_WRITE  = 8'h90;
  localparam logic [7:0] CMD_CHG_MRD   = 8'ha0;
  localparam logic [7:0] CMD_CHG_ORD   = 8'ha8;
  localparam logic [7:0] CMD_CHG_MWR   = 8'hb0;
  localparam logic [7:0] CMD_CHG_OWR   = 8'hb8;
  localparam logic [7:0] CMD_CHG_RST   = 8'hc0;
  localparam logic [7:0] CMD_NP_READ   = 8'hc8;
  localparam logic [7:0] CMD_NP_WRITE  = 8'hd8;
  localparam logic [7:0] CMD_RESET_DEV = 8'he8;
  localparam logic [7:0] CMD_POLL      = 8'hf0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  // arbitrary factory password
  localparam logic [63:0] PWD_RESET = 64'h0;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_CMD   = 4'h1,
    ST_PWD   = 4'h3,
    ST_ADRH  = 4'h2,
    ST_ADRL  = 4'h6,
    ST_RDATA = 4'h7,
    ST_WDATA = 4'h5,
    ST_RADR  = 4'h4,
    ST_ZERO  = 4'hc,
    ST_NEWPW = 4'hd,
    ST_IGN   = 4'he
  } ctl_state_t;

endpackage

/* File: link_if.sv */
`timescale 1ns/1ps
interface link_if;
  logic [7:0] rxByte;
  logic       byteTgl;
  logic       ackBit;
  logic       ackTgl;
  logic       clr;

  modport link (output rxByte, output byteTgl, output ackBit, output ackTgl, input clr);
  modport ctrl (input rxByte, input byteTgl, input ackBit, input ackTgl, output clr);
endinterface

/* File: twowire_link.sv */
`timescale 1ns/1ps
module twowire_link (
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic rst_n,
  link_if.link     lnk
);

  typedef struct packed {
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] rxByte;
    logic       byteTgl;
    logic       ackBit;
    logic       ackTgl;
  } lk_t;

  lk_t  r_r;
  lk_t  r_nxt;
  logic linkRst_n;

  // frame clear from the control side restarts bit framing at each start/stop
  assign linkRst_n = rst_n & ~lnk.clr;

  always_comb
  begin
    r_nxt = r_r;
    if (r_r.cnt == eeprom_pkg::BIT_ACK)
    begin
      r_nxt.ackBit = ~sdaIn;
      r_nxt.ackTgl = ~r_r.ackTgl;
      r_nxt.cnt    = 4'h0;
    end
    else
    begin
      r_nxt.sh  = {r_r.sh[6:0], sdaIn};
      r_nxt.cnt = r_r.cnt + 4'h1;
      if (r_r.cnt == eeprom_pkg::BIT_LAST)
      begin
        r_nxt.rxByte  = {r_r.sh[6:0], sdaIn};
        r_nxt.byteTgl = ~r_r.byteTgl;
      end
    end
  end

  // toggles reset with the frame; control side discards them while clr stands
  always_ff @(posedge scl or negedge linkRst_n)
  begin
    if (!linkRst_n)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  assign lnk.rxByte  = r_r.rxByte;
  assign lnk.byteTgl = r_r.byteTgl;
  assign lnk.ackBit  = r_r.ackBit;
  assign lnk.ackTgl  = r_r.ackTgl;

endmodule

/* File: eeprom_access.sv */
// Summary of operation
// RL1: random read: command, address, then new low address
// RL2: no-password random read refused in protected region
// RL3: pointer steps 00FF to 0100 after output
// RL4: sequential read increments every address bit
// RL5: no-password read stops idle at 1FFF
// RL6: host acknowledges each byte except last
// RL7: host ends read with stop, ack optional
// RL8: clocking on after first byte reads onward
// RL9: no new random address after two bytes
// RL10: chained random reads, sequential read last
// RL11: no sequential read after last-byte random read
// RL12: password commands reach unprotected region normally
// RL13: no-password protected address gets not-acknowledge
// RL14: password sequential read never rolls to zero
// RL15: no-password read never wraps into protected region
// RL16: change: command, old password, poll, zeros, twice
// RL17: store only on matching copies, sixteen bytes
// RL18: compare after second copy, mismatch goes standby
// RL19: early poll: ack mismatch, nack while writing
// RL20: last new-password byte acked only when valid
// RL21: passwords can never be read back
// RL22: code C8 is no-password array read
// RL23: after password, poll F0 acks when correct, done
// RL24: illegal command not-acknowledged, back to standby
// RL25: single address byte replaces only low byte
`timescale 1ns/1ps
module eeprom_access #(
  parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output      logic        sdaOut,
  output      logic        sdaOe,
  input  wire logic [12:0] protLimit,
  output      logic        writeBusy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    eeprom_pkg::ctl_state_t st;
    logic [1:0]        sclS;
    logic              sclD;
    logic [1:0]        sdaS;
    logic              sdaD;
    logic [1:0]        bTgS;
    logic              bTgD;
    logic [1:0]        aTgS;
    logic              aTgD;
    logic [12:0]       protS1;
    logic [12:0]       protS2;
    logic              clr;
    logic [3:0]        ph;
    logic              sdaOe;
    logic              sdaOut;
    logic              ackNext;
    logic              txOn;
    logic              rdStop;
    logic [7:0]        cmd;
    logic [12:0]       addr;
    logic [1:0]        rdCnt;
    logic              atEnd;
    logic              pwdOk;
    logic              pendPw;
    logic [4:0]        cnt;
    logic              entErr;
    logic              entOk;
    logic [63:0]       newA;
    logic [63:0]       newB;
    logic              busy;
    logic [20:0]       timer;
    logic [4:0][63:0]  pwd;
  } ctl_t;

  ctl_t        r_r;
  ctl_t        r_nxt;
  logic [7:0]  mem [0:8191];
  logic [7:0]  rdData;
  logic        memWe;
  logic [7:0]  rxb;
  logic        byteEv;
  logic        ackEv;
  logic        fallEv;
  logic        startEv;
  logic        stopEv;
  logic [3:0]  phNxt;
  logic [12:0] newAddr;
  logic [7:0]  pwByte;
  logic        newOk;

  link_if lnkBus ();

  twowire_link u_link (
    .scl   (scl),
    .sdaIn (sdaIn),
    .rst_n (rst_n),
    .lnk   (lnkBus)
  );

  assign lnkBus.clr = r_r.clr;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] pwIdx(input logic [7:0] c);
    case (c)
      eeprom_pkg::CMD_PW_READ,  eeprom_pkg::CMD_CHG_MRD: pwIdx = 3'h0;
      eeprom_pkg::CMD_CHG_ORD:                           pwIdx = 3'h1;
      eeprom_pkg::CMD_PW_WRITE, eeprom_pkg::CMD_CHG_MWR: pwIdx = 3'h2;
      eeprom_pkg::CMD_CHG_OWR:                           pwIdx = 3'h3;
      eeprom_pkg::CMD_CHG_RST:                           pwIdx = 3'h4;
      default:                                           pwIdx = 3'h0;
    endcase
  endfunction

  function automatic logic isNoPw(input logic [7:0] c);
    isNoPw = (c == eeprom_pkg::CMD_NP_READ) || (c == eeprom_pkg::CMD_NP_WRITE);
  endfunction

  function automatic logic isRead(input logic [7:0] c);
    isRead = (c == eeprom_pkg::CMD_NP_READ) || (c == eeprom_pkg::CMD_PW_READ);
  endfunction

  // ----------------------------------------------------------------
  // control
  // ----------------------------------------------------------------
  always_comb
  begin
    r_nxt   = r_r;
    memWe   = 1'b0;
    rxb     = lnkBus.rxByte;
    byteEv  = (r_r.bTgS[1] != r_r.bTgD) && !r_r.clr;
    ackEv   = (r_r.aTgS[1] != r_r.aTgD) && !r_r.clr;
    fallEv  = r_r.sclD & ~r_r.sclS[1];
    startEv = r_r.sclS[1] & r_r.sdaD & ~r_r.sdaS[1];
    stopEv  = r_r.sclS[1] & ~r_r.sdaD & r_r.sdaS[1];
    phNxt   = (r_r.ph == eeprom_pkg::BIT_ACK) ? 4'h0 : r_r.ph + 4'h1;
    newAddr = {r_r.addr[12:8], rxb};
    pwByte  = 8'(r_r.pwd[pwIdx(r_r.cmd)] >> {3'h7 - r_r.cnt[2:0], 3'h0});
    newOk   = !r_r.entErr && ({r_r.newB[55:0], rxb} == r_r.newA);

    r_nxt.sclS   = {r_r.sclS[0], scl};
    r_nxt.sclD   = r_r.sclS[1];
    r_nxt.sdaS   = {r_r.sdaS[0], sdaIn};
    r_nxt.sdaD   = r_r.sdaS[1];
    r_nxt.bTgS   = {r_r.bTgS[0], lnkBus.byteTgl};
    r_nxt.bTgD   = r_r.bTgS[1];
    r_nxt.aTgS   = {r_r.aTgS[0], lnkBus.ackTgl};
    r_nxt.aTgD   = r_r.aTgS[1];
    r_nxt.protS1 = protLimit;
    r_nxt.protS2 = r_r.protS1;

    // nonvolatile cycle timer
    if (r_r.busy)
    begin
      r_nxt.timer = r_r.timer - 21'h1;
      if (r_r.timer == 21'h1)
        r_nxt.busy = 1'b0;
    end

    if (byteEv && r_r.st != eeprom_pkg::ST_RDATA)
    begin
      r_nxt.ackNext = 1'b0;
      case (r_r.st)
        eeprom_pkg::ST_CMD:
        begin
          r_nxt.st = eeprom_pkg::ST_IGN;
          if (rxb == eeprom_pkg::CMD_POLL)
          begin
            if (r_r.pendPw)
            begin
              if (r_r.pwdOk && !r_r.busy)                                 // RL23
              begin
                r_nxt.ackNext = 1'b0 | 1'b1;
                r_nxt.pendPw  = 1'b0;
                r_nxt.cnt     = 5'h0;
                r_nxt.st      = (r_r.cmd == eeprom_pkg::CMD_PW_READ ||
                                 r_r.cmd == eeprom_pkg::CMD_PW_WRITE) ?
                                eeprom_pkg::ST_ADRH : eeprom_pkg::ST_ZERO;  // RL16
              end
            end
            else
              r_nxt.ackNext = ~r_r.busy;                                  // RL19
          end
          else if (!r_r.busy)
          begin
            r_nxt.pendPw = 1'b0;
            r_nxt.cnt    = 5'h0;
            r_nxt.pwdOk  = 1'b1;
            r_nxt.cmd    = rxb;
            r_nxt.entErr = 1'b0;
            case (rxb)
              eeprom_pkg::CMD_NP_READ, eeprom_pkg::CMD_NP_WRITE:          // RL22
              begin
                r_nxt.ackNext = 1'b1;
                r_nxt.st      = eeprom_pkg::ST_ADRH;
              end
              eeprom_pkg::CMD_PW_READ, eeprom_pkg::CMD_PW_WRITE,
              eeprom_pkg::CMD_CHG_MRD, eeprom_pkg::CMD_CHG_ORD,
              eeprom_pkg::CMD_CHG_MWR, eeprom_pkg::CMD_CHG_OWR,
              eeprom_pkg::CMD_CHG_RST:
              begin
                r_nxt.ackNext = 1'b1;
                r_nxt.st      = eeprom_pkg::ST_PWD;
              end
              eeprom_pkg::CMD_RESET_DEV: r_nxt.ackNext = 1'b1;
              default:                   r_nxt.ackNext = 1'b0;             // RL24
            endcase
          end
        end
        eeprom_pkg::ST_PWD:
        begin
          r_nxt.ackNext = 1'b1;
          r_nxt.pwdOk   = r_r.pwdOk & (rxb == pwByte);
          r_nxt.cnt     = r_r.cnt + 5'h1;
          if (r_r.cnt == eeprom_pkg::PW_LAST)
          begin
            // a cycle runs even for a wrong password, to slow guessing
            r_nxt.pendPw = 1'b1;
            r_nxt.busy   = 1'b1;
            r_nxt.timer  = 21'(WRITE_CYCLES);
            r_nxt.st     = eeprom_pkg::ST_IGN;
          end
        end
        eeprom_pkg::ST_ADRH:
        begin
          r_nxt.ackNext    = 1'b1;
          r_nxt.addr[12:8] = rxb[4:0];
          r_nxt.st         = eeprom_pkg::ST_ADRL;
        end
        eeprom_pkg::ST_ADRL, eeprom_pkg::ST_RADR:
        begin
          r_nxt.addr  = newAddr;                                          // RL25
          r_nxt.rdCnt = 2'h0;
          r_nxt.atEnd = 1'b0;
          if (isNoPw(r_r.cmd) && newAddr < r_r.protS2)                    // RL2 RL13 RL15
            r_nxt.st = eeprom_pkg::ST_IGN;
          else
          begin
            r_nxt.ackNext = 1'b1;                                         // RL12
            r_nxt.st = isRead(r_r.cmd) ? eeprom_pkg::ST_RDATA : eeprom_pkg::ST_WDATA;
          end
        end
        eeprom_pkg::ST_WDATA:
        begin
          memWe         = 1'b1;
          r_nxt.ackNext = 1'b1;
          r_nxt.addr    = r_r.addr + 13'h1;
        end
        eeprom_pkg::ST_ZERO:
        begin
          r_nxt.ackNext = 1'b1;
          r_nxt.entErr  = r_r.entErr | (rxb != 8'h00);
          r_nxt.cnt     = r_r.cnt + 5'h1;
          if (r_r.cnt == eeprom_pkg::ZERO_LAST)
          begin
            r_nxt.cnt = 5'h0;
            r_nxt.st  = eeprom_pkg::ST_NEWPW;
          end
        end
        eeprom_pkg::ST_NEWPW:
        begin
          r_nxt.cnt = r_r.cnt + 5'h1;
          if (r_r.cnt < eeprom_pkg::NEW_HALF)
          begin
            r_nxt.newA    = {r_r.newA[55:0], rxb};
            r_nxt.ackNext = 1'b1;
          end
          else if (r_r.cnt < eeprom_pkg::NEW_LAST)
          begin
            r_nxt.newB    = {r_r.newB[55:0], rxb};
            r_nxt.ackNext = 1'b1;
          end
          else if (r_r.cnt == eeprom_pkg::NEW_LAST)
          begin
            r_nxt.newB    = {r_r.newB[55:0], rxb};
            r_nxt.ackNext = newOk;                                        // RL20
            r_nxt.entOk   = newOk;                                        // RL18
            if (!newOk)
              r_nxt.st = eeprom_pkg::ST_IGN;
          end
          else
          begin
            r_nxt.entErr = 1'b1;                                          // RL17
            r_nxt.entOk  = 1'b0;
            r_nxt.st     = eeprom_pkg::ST_IGN;
          end
        end
        default: r_nxt.ackNext = 1'b0;
      endcase
    end

    // host acknowledge after a transmitted byte
    if (ackEv && r_r.txOn && !lnkBus.ackBit)
      r_nxt.rdStop = 1'b1;

    // sda is only changed while scl is low
    if (fallEv)
    begin
      r_nxt.ph = phNxt;
      if (phNxt == eeprom_pkg::BIT_ACK)
      begin
        if (r_r.txOn)
        begin
          r_nxt.sdaOe = 1'b0;
          if (r_r.rdCnt != 2'h2)
            r_nxt.rdCnt = r_r.rdCnt + 2'h1;
          if (r_r.addr == eeprom_pkg::ADDR_TOP)                           // RL5 RL14
            r_nxt.atEnd = 1'b1;
          else
            r_nxt.addr = r_r.addr + 13'h1;                                // RL3 RL4 RL8
        end
        else
          r_nxt.sdaOe = r_r.ackNext;
      end
      else
      begin
        if (phNxt == 4'h0)
        begin
          r_nxt.txOn    = (r_r.st == eeprom_pkg::ST_RDATA);
          r_nxt.ackNext = 1'b0;
        end
        // past the top the line floats high: reads return all ones
        r_nxt.sdaOe = (phNxt == 4'h0 ? r_r.st == eeprom_pkg::ST_RDATA : r_r.txOn) &&
                      !r_r.atEnd && !r_r.rdStop && !rdData[3'h7 - phNxt[2:0]];
      end
    end

    if (r_r.clr && !r_r.sclS[1])
      r_nxt.clr = 1'b0;

    if (startEv)
    begin
      r_nxt.clr    = 1'b1;
      r_nxt.ph     = eeprom_pkg::BIT_ACK;
      r_nxt.sdaOe  = 1'b0;
      r_nxt.txOn   = 1'b0;
      r_nxt.rdStop = 1'b0;
      r_nxt.rdCnt  = 2'h0;
      r_nxt.entOk  = 1'b0;
      // exactly one byte out and not at the top: next byte is a low address
      if (r_r.st == eeprom_pkg::ST_RDATA && r_r.rdCnt == 2'h1 && !r_r.atEnd) // RL1 RL9 RL10
        r_nxt.st = eeprom_pkg::ST_RADR;
      else
        r_nxt.st = eeprom_pkg::ST_CMD;
    end

    if (stopEv)
    begin
      if (r_r.st == eeprom_pkg::ST_NEWPW && r_r.entOk && r_r.cnt == eeprom_pkg::NEW_COUNT)
      begin
        r_nxt.pwd[pwIdx(r_r.cmd)] = r_r.newA;                             // RL17
        r_nxt.busy  = 1'b1;
        r_nxt.timer = 21'(WRITE_CYCLES);
      end
      r_nxt.clr    = 1'b1;
      r_nxt.st     = eeprom_pkg::ST_IDLE;
      r_nxt.pendPw = 1'b0;
      r_nxt.entOk  = 1'b0;
      r_nxt.sdaOe  = 1'b0;
      r_nxt.txOn   = 1'b0;
      r_nxt.rdStop = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_r      <= '0;
      r_r.st   <= eeprom_pkg::ST_IDLE;
      r_r.sclS <= 2'h3;
      r_r.sclD <= 1'b1;
      r_r.sdaS <= 2'h3;
      r_r.sdaD <= 1'b1;
      r_r.clr  <= 1'b1;
      r_r.ph   <= eeprom_pkg::BIT_ACK;
      r_r.pwd  <= {5{eeprom_pkg::PWD_RESET}};
    end
    else
      r_r <= r_nxt;
  end

  // ----------------------------------------------------------------
  // array; passwords live apart and have no read path
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (memWe)
      mem[r_r.addr] <= rxb;
    rdData <= mem[r_r.addr];                                              // RL21
  end

  assign sdaOut    = r_r.sdaOut;
  assign sdaOe     = r_r.sdaOe;
  assign writeBusy = r_r.busy;

endmodule

/* File: eeprom_access_chk.sv */
`timescale 1ns/1ps
module eeprom_access_chk #(
  parameter int unsigned WRITE_CYCLES = 200
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        scl,
  input wire logic        sdaIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic [12:0] protLimit,
  input wire logic        writeBusy
);
  // ------------------------------------------------------------
  // bus observer
  // ------------------------------------------------------------
  // raw pins sampled in mclk; bus phases are far longer than a cycle
  logic        sclQ_r;
  logic        sdaQ_r;
  logic        first_r;
  logic        idle_r;
  logic [3:0]  bitCnt_r;
  logic [7:0]  shift_r;
  int unsigned busyCnt_r;
  logic        startSeen;
  logic        stopSeen;
  logic        sclRise;
  logic        ackPhase;
  logic        legal;
  assign startSeen = scl && sclQ_r && sdaQ_r && !sdaIn;
  assign stopSeen  = scl && sclQ_r && !sdaQ_r && sdaIn;
  assign sclRise   = scl && !sclQ_r;
  assign ackPhase  = sclRise && first_r && (bitCnt_r == 4'h8);
  assign legal     = shift_r inside {8'h80, 8'h90, 8'ha0, 8'ha8, 8'hb0, 8'hb8,
                                     8'hc0, 8'hc8, 8'hd8, 8'he8, 8'hf0};
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclQ_r    <= 1'b1;
      sdaQ_r    <= 1'b1;
      first_r   <= 1'b0;
      idle_r    <= 1'b1;
      bitCnt_r  <= 4'h0;
      shift_r   <= 8'h00;
      busyCnt_r <= 0;
    end
    else
    begin
      sclQ_r    <= scl;
      sdaQ_r    <= sdaIn;
      busyCnt_r <= writeBusy ? busyCnt_r + 1 : 0;
      if (stopSeen)
        idle_r <= 1'b1;
      // a repeated start may open a chained address byte: judge commands after a stop or reset only
      if (startSeen)
      begin
        first_r  <= idle_r;
        idle_r   <= 1'b0;
        bitCnt_r <= 4'h0;
      end
      else if (sclRise)
      begin
        shift_r  <= {shift_r[6:0], sdaIn};
        bitCnt_r <= (bitCnt_r == 4'h8) ? 4'h0 : bitCnt_r + 4'h1;
        if (bitCnt_r == 4'h8)
          first_r <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_busyRun;
    writeBusy [*8];
  endsequence
  property p_illegal; ackPhase && !legal |-> sdaIn; endproperty
  property p_npAck; ackPhase && shift_r == 8'hc8 && !writeBusy |-> !sdaIn; endproperty
  property p_busyPoll; ackPhase && shift_r == 8'hf0 && writeBusy |-> sdaIn; endproperty
  property p_busyLen; $fell(writeBusy) |-> busyCnt_r == WRITE_CYCLES; endproperty
  property p_busyHold; $rose(writeBusy) |-> s_busyRun; endproperty
  property p_rstQuiet; $rose(rst_n) |-> !sdaOe && !writeBusy && !sdaOut; endproperty
  property p_oeLow; $rose(sdaOe) |-> !scl && !sclQ_r; endproperty
  property p_startRel; startSeen |-> ##[1:8] !sdaOe; endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal command byte was acknowledged");
  a_npAck: assert property (p_npAck)
    else $error("array read command not acknowledged");
  a_busyPoll: assert property (p_busyPoll)
    else $error("poll acknowledged during write cycle");
  a_busyLen: assert property (p_busyLen)
    else $error("write cycle length wrong");
  a_busyHold: assert property (p_busyHold)
    else $error("write cycle ended at once");
  a_rstQuiet: assert property (p_rstQuiet)
    else $error("outputs active just after reset");
  a_oeLow: assert property (p_oeLow)
    else $error("sda driven while clock high");
  a_startRel: assert property (p_startRel)
    else $error("sda held after start");
endmodule

bind eeprom_access eeprom_access_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_eeprom_access_chk (
  .mclk(mclk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .protLimit(protLimit), .writeBusy(writeBusy));

/* File: twowire_host.sv */
`timescale 1ns/1ps
module twowire_host (
  input  wire logic lclk,
  input  wire logic sda,
  output      logic scl,
  output      logic hostOe
);
  // 7 link ticks a phase keeps scl low and high above 100 ns
  localparam int PHASE = 7;
  initial
  begin
    scl    = 1'b1;
    hostOe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask
  // sda moves two ticks after scl falls, never beside the edge
  task automatic bitx(input logic b, output logic r);
    tick(2);
    hostOe <= ~b;
    tick(PHASE - 2);
    scl <= 1'b1;
    tick(PHASE);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic start;
    tick(2);
    hostOe <= 1'b0;
    tick(PHASE);
    scl <= 1'b1;
    tick(PHASE);
    hostOe <= 1'b1;
    tick(PHASE);
    scl <= 1'b0;
  endtask
  task automatic stop;
    tick(2);
    hostOe <= 1'b1;
    tick(PHASE);
    scl <= 1'b1;
    tick(PHASE);
    hostOe <= 1'b0;
    tick(PHASE);
  endtask
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rdByte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(~ackIt, r);
  endtask
endmodule

/* File: eeprom_access_tb.sv */
`timescale 1ns/1ps
module eeprom_access_tb;
  localparam int unsigned WCYC  = 800;
  localparam logic [63:0] NEWPW = 64'h0123_4567_89ab_cdef;
  logic        mclk            = 1'b0;
  logic        lclk            = 1'b0;
  logic        rst_n           = 1'b0;
  logic [12:0] protLimit       = 13'h0080;
  logic        scl;
  logic        hostOe;
  logic        sdaIn;
  logic        sdaOut;
  logic        sdaOe;
  logic        writeBusy;
  int          err_total       = 0;
  int          samples_checked = 0;
  int          cycles          = 0;
  // pulled-up open-drain wire
  assign sdaIn = ~(sdaOe | hostOe);
  always #2 mclk = ~mclk;
  always #7.5 lclk = ~lclk;
  eeprom_access #(.WRITE_CYCLES(WCYC)) u_eeprom_access (.mclk(mclk), .rst_n(rst_n),
    .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .protLimit(protLimit),
    .writeBusy(writeBusy));
  twowire_host u_twowire_host (.lclk(lclk), .sda(sdaIn), .scl(scl), .hostOe(hostOe));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic wb(input logic [7:0] d, input logic expAck, input string what);
    logic a;
    u_twowire_host.wrByte(d, a);
    chk(what, {7'h0, expAck}, {7'h0, a});
  endtask
  task automatic rb(input logic ackIt, input logic [7:0] exp, input string what);
    logic [7:0] d;
    u_twowire_host.rdByte(ackIt, d);
    chk(what, exp, d);
  endtask
  task automatic pw(input logic [63:0] p);
    for (int i = 7; i >= 0; i--)
      wb(p[i*8 +: 8], 1'b1, "password byte ack");
  endtask
  // bounded retry: a write cycle outlasts one poll byte but not two
  task automatic poll(input logic expAck, input int tries);
    logic a;
    for (int i = 0; i < tries; i++)
    begin
      u_twowire_host.start();
      u_twowire_host.wrByte(eeprom_pkg::CMD_POLL, a);
      if (a === 1'b1)
        break;
    end
    chk("poll ack", {7'h0, expAck}, {7'h0, a});
  endtask
  task automatic rdAt(input logic [12:0] a);
    u_twowire_host.start();
    wb(eeprom_pkg::CMD_NP_READ, 1'b1, "read cmd ack");
    wb({3'h0, a[12:8]}, 1'b1, "addr hi ack");
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_write(input logic [12:0] a, input logic [31:0] d, input int n);
    u_twowire_host.start();
    wb(eeprom_pkg::CMD_NP_WRITE, 1'b1, "write cmd ack");
    wb({3'h0, a[12:8]}, 1'b1, "addr hi ack");
    wb(a[7:0], 1'b1, "addr lo ack");
    for (int i = 0; i < n; i++)
      wb(d[31-8*i -: 8], 1'b1, "write data ack");
    u_twowire_host.stop();
    poll(1'b1, 4);
    u_twowire_host.stop();
    $display("test write done");
  endtask
  task automatic t_random;
    rdAt(13'h0000);
    wb(8'hfe, 1'b1, "addr lo ack");
    rb(1'b0, 8'h11, "random data 00fe");
    u_twowire_host.start();
    wb(8'hff, 1'b1, "chain addr ack");
    rb(1'b0, 8'h22, "random data 00ff");
    u_twowire_host.start();
    wb(8'h00, 1'b1, "chain addr ack");
    rb(1'b1, 8'h33, "random data 0100");
    rb(1'b0, 8'h44, "onward data 0101");
    u_twowire_host.start();
    wb(8'h01, 1'b0, "chain after two bytes");
    u_twowire_host.stop();
    $display("test random done");
  endtask
  task automatic t_refuse;
    rdAt(13'h0000);
    wb(8'h7f, 1'b0, "protected addr lo nack");
    u_twowire_host.stop();
    u_twowire_host.start();
    wb(8'h55, 1'b0, "illegal cmd nack");
    wb(8'h00, 1'b0, "byte after illegal");
    u_twowire_host.stop();
    u_twowire_host.start();
    wb(eeprom_pkg::CMD_RESET_DEV, 1'b1, "reset cmd ack");
    u_twowire_host.stop();
    rdAt(13'h1f00);
    wb(8'hfe, 1'b1, "addr lo ack");
    rb(1'b1, 8'h55, "seq data 1ffe");
    rb(1'b1, 8'h66, "seq data 1fff");
    rb(1'b0, 8'hff, "past top idle");
    u_twowire_host.stop();
    $display("test refuse done");
  endtask
  task automatic t_chg(input logic [63:0] b, input logic good);
    u_twowire_host.start();
    wb(eeprom_pkg::CMD_CHG_MRD, 1'b1, "change cmd ack");
    pw(eeprom_pkg::PWD_RESET);
    poll(1'b1, 4);
    wb(8'h00, 1'b1, "zero ack");
    wb(8'h00, 1'b1, "zero ack");
    pw(NEWPW);
    for (int i = 7; i >= 1; i--)
      wb(b[i*8 +: 8], 1'b1, "copy b ack");
    wb(b[7:0], good, "copy b last ack");
    u_twowire_host.stop();
    u_twowire_host.start();
    wb(eeprom_pkg::CMD_POLL, ~good, "early poll");
    if (good)
      poll(1'b1, 4);
    u_twowire_host.stop();
    $display("test change done");
  endtask
  task automatic t_pwRead;
    u_twowire_host.start();
    wb(eeprom_pkg::CMD_PW_READ, 1'b1, "pw read cmd ack");
    pw(eeprom_pkg::PWD_RESET);
    poll(1'b0, 3);
    u_twowire_host.stop();
    u_twowire_host.start();
    wb(eeprom_pkg::CMD_PW_READ, 1'b1, "pw read cmd ack");
    pw(NEWPW);
    poll(1'b1, 4);
    wb(8'h01, 1'b1, "addr hi ack");
    wb(8'h00, 1'b1, "addr lo ack");
    rb(1'b0, 8'h33, "pw read unprotected");
    u_twowire_host.stop();
    $display("test password read done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      $display("timeout after %0d cycles", cycles);
      err_total++;
      stop_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_write(13'h00fe, 32'h11223344, 4);
    t_write(13'h1ffe, 32'h55660000, 2);
    t_random();
    t_refuse();
    t_chg(NEWPW ^ 64'h1, 1'b0);
    t_chg(NEWPW, 1'b1);
    t_pwRead();
    stop_test();
  end
endmodule
